// file: core/aurx_pkg.sv
package aurx_pkg;

  // Register indexes on the plain register port
  localparam logic [2:0] ADDR_RX_DATA = 3'h0;
  localparam logic [2:0] ADDR_RX_STATUS_CTRL = 3'h1;
  localparam logic [2:0] ADDR_BAUD_DIVISOR = 3'h2;
  localparam logic [2:0] ADDR_TX_STATUS_CTRL = 3'h3;
  localparam logic [2:0] ADDR_INT_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;

  // Receive status/control field positions
  localparam int RS_PORT_ENABLE = 7;
  localparam int RS_NINE_BIT = 6;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX = 4;
  localparam int RS_ADDR_DETECT = 3;
  localparam int RS_FRAMING = 2;
  localparam int RS_OVERRUN = 1;
  localparam int RS_NINTH = 0;

  // Transmit status/control field positions
  localparam int TS_CLOCK_SRC = 7;
  localparam int TS_TX_NINE_BIT = 6;
  localparam int TS_TX_ENABLE = 5;
  localparam int TS_SYNC_MODE = 4;
  localparam int TS_HIGH_BAUD = 2;
  localparam int TS_TX_SHIFT_EMPTY = 1;
  localparam int TS_TX_NINTH = 0;
  localparam logic [7:0] TS_WRITE_MASK = 8'hF5;

  // Interrupt control field positions
  localparam int IC_RX_INT_ENABLE = 0;
  localparam int IC_PERIPH_INT_ENABLE = 1;
  localparam int IC_GLOBAL_INT_ENABLE = 2;
  localparam int IC_RX_AVAILABLE = 7;

  // Sticky event bits, shared by status and mask
  localparam int EV_CHAR = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_FRAMING = 2;
  localparam int EV_WIDTH = 3;

  // Reset values
  localparam logic [7:0] RX_STATUS_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_STATUS_CTRL_RESET = 8'h02;
  localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
  localparam logic [7:0] RX_DATA_RESET = 8'h00;

  // Oversampling timing
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] SAMPLE_END = 4'hF;
  localparam int LOW_BAUD_MULT = 4;

  // Receiver states
  typedef enum logic [1:0] {
    AURX_IDLE,
    AURX_START,
    AURX_DATA,
    AURX_STOP
  } aurx_state_t;

endpackage

// file: core/aurx_receiver.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module aurx_receiver (
  input wire logic clock,
  input wire logic rst,
  input wire logic rx_line,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic rx_int_request,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations

  aurx_tick_if tk ();

  logic [7:0] rx_status_ctrl;
  logic [7:0] next_rx_status_ctrl;
  logic [7:0] tx_status_ctrl;
  logic [7:0] next_tx_status_ctrl;
  logic [7:0] baud_divisor;
  logic [7:0] next_baud_divisor;
  logic [2:0] int_control;
  logic [2:0] next_int_control;
  logic [aurx_pkg::EV_WIDTH-1:0] irq_status;
  logic [aurx_pkg::EV_WIDTH-1:0] next_irq_status;
  logic [aurx_pkg::EV_WIDTH-1:0] irq_mask;
  logic [aurx_pkg::EV_WIDTH-1:0] next_irq_mask;
  logic [7:0] next_reg_rdata;

  aurx_pkg::aurx_state_t state;
  aurx_pkg::aurx_state_t next_state;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [1:0] votes;
  logic [1:0] next_votes;
  logic [8:0] rx_shift_register;
  logic [8:0] next_rx_shift_register;
  logic line_prev;

  // Buffer entries: framing bit, ninth bit, eight data bits
  logic [9:0] buf_mem [2];
  logic [9:0] next_buf_mem [2];
  logic buf_head;
  logic next_buf_head;
  logic [1:0] buf_count;
  logic [1:0] next_buf_count;

  logic port_enable;
  logic rx_nine_bit_select;
  logic continuous_rx_enable;
  logic address_detect_enable;
  logic overrun_error_flag;
  logic framing_error_flag;
  logic rx_ninth_bit;
  logic rx_data_available_flag;
  logic rx_active;
  logic last_data_bit;
  logic sample_bit;
  logic pop;
  logic push;
  logic char_done;
  logic stop_bad;
  logic [aurx_pkg::EV_WIDTH-1:0] events;

  ////////////////////////////////////////////////////////////////////////
  // Field views

  assign port_enable = rx_status_ctrl[aurx_pkg::RS_PORT_ENABLE];
  assign rx_nine_bit_select = rx_status_ctrl[aurx_pkg::RS_NINE_BIT];
  assign continuous_rx_enable = rx_status_ctrl[aurx_pkg::RS_CONT_RX];
  assign address_detect_enable = rx_status_ctrl[aurx_pkg::RS_ADDR_DETECT];
  assign overrun_error_flag = rx_status_ctrl[aurx_pkg::RS_OVERRUN];
  // Flags of the oldest unread character
  assign framing_error_flag = (buf_count != 2'h0) && buf_mem[buf_head][9];
  assign rx_ninth_bit = (buf_count != 2'h0) &&
                        (buf_mem[buf_head][8] || address_detect_enable);
  assign rx_data_available_flag = port_enable && buf_count != 2'h0;
  // Receiver runs only while enabled, asynchronous and free of overrun
  assign rx_active = port_enable && continuous_rx_enable && !overrun_error_flag &&
                     !tx_status_ctrl[aurx_pkg::TS_SYNC_MODE];

  ////////////////////////////////////////////////////////////////////////
  // Oversample tick

  assign tk.run = state != aurx_pkg::AURX_IDLE;
  assign tk.high_baud_select = tx_status_ctrl[aurx_pkg::TS_HIGH_BAUD];
  assign tk.baud_divisor = baud_divisor;

  aurx_tick_gen #(
    .CNT_W(10)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .tk(tk.gen)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bit recovery

  // Majority of three samples around the bit centre
  assign sample_bit = votes[1] || (votes[0] && rx_line);
  assign last_data_bit = bit_idx == (rx_nine_bit_select ? 4'h8 : 4'h7);
  assign char_done = state == aurx_pkg::AURX_STOP && tk.tick &&
                     phase == aurx_pkg::SAMPLE_LAST;
  assign stop_bad = !sample_bit;

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_bit_idx = bit_idx;
    next_votes = votes;
    next_rx_shift_register = rx_shift_register;
    if (tk.tick) begin
      next_phase = phase + 4'h1;
      if (phase == aurx_pkg::SAMPLE_FIRST) begin
        next_votes = {1'b0, rx_line};
      end else if (phase == aurx_pkg::SAMPLE_MID) begin
        next_votes = votes[0] ? (rx_line ? 2'h2 : 2'h1) : {1'b0, rx_line};
      end
    end
    case (state)
      aurx_pkg::AURX_IDLE: begin
        next_phase = 4'h0;
        next_bit_idx = 4'h0;
        // Falling edge opens a character
        if (rx_active && line_prev && !rx_line) begin
          next_state = aurx_pkg::AURX_START;
          next_rx_shift_register = 9'h000;
        end
      end
      aurx_pkg::AURX_START: begin
        // High at mid start bit: silent abort
        if (tk.tick && phase == aurx_pkg::SAMPLE_MID && rx_line) begin
          next_state = aurx_pkg::AURX_IDLE;
        end else if (tk.tick && phase == aurx_pkg::SAMPLE_END) begin
          next_state = aurx_pkg::AURX_DATA;
        end
      end
      aurx_pkg::AURX_DATA: begin
        if (tk.tick && phase == aurx_pkg::SAMPLE_LAST) begin
          next_rx_shift_register[bit_idx] = sample_bit;
        end
        if (tk.tick && phase == aurx_pkg::SAMPLE_END) begin
          next_bit_idx = bit_idx + 4'h1;
          if (last_data_bit) begin
            next_state = aurx_pkg::AURX_STOP;
          end
        end
      end
      aurx_pkg::AURX_STOP: begin
        // Character ends at the stop-bit centre
        if (char_done) begin
          next_state = aurx_pkg::AURX_IDLE;
        end
      end
      default: begin
        next_state = aurx_pkg::AURX_IDLE;
      end
    endcase
    // Port or receiver disabled aborts any character
    if (!rx_active) begin
      next_state = aurx_pkg::AURX_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= aurx_pkg::AURX_IDLE;
      phase <= 4'h0;
      bit_idx <= 4'h0;
      votes <= 2'h0;
      rx_shift_register <= 9'h000;
      line_prev <= 1'b1;
    end else begin
      state <= next_state;
      phase <= next_phase;
      bit_idx <= next_bit_idx;
      votes <= next_votes;
      rx_shift_register <= next_rx_shift_register;
      line_prev <= rx_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer

  assign pop = reg_read && reg_addr == aurx_pkg::ADDR_RX_DATA && buf_count != 2'h0;
  // Address detect drops characters whose ninth bit is zero
  assign push = char_done && (!address_detect_enable ||
                (rx_nine_bit_select && rx_shift_register[8]));

  function automatic logic sample_ninth();
    sample_ninth = rx_nine_bit_select && rx_shift_register[8];
  endfunction

  always_comb begin
    next_buf_mem = buf_mem;
    next_buf_head = buf_head;
    next_buf_count = buf_count;
    if (pop) begin
      next_buf_head = !buf_head;
      next_buf_count = buf_count - 2'h1;
    end
    // A pop in the same cycle frees a slot for the arriving character
    if (push && (buf_count != 2'h2 || pop)) begin
      next_buf_mem[1'(buf_head + buf_count[0])] =
        {stop_bad, sample_ninth(), rx_shift_register[7:0]};
      next_buf_count = next_buf_count + 2'h1;
    end
    // Port disabled holds the buffer empty
    if (!port_enable) begin
      next_buf_head = 1'b0;
      next_buf_count = 2'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      buf_mem[0] <= 10'h000;
      buf_mem[1] <= 10'h000;
      buf_head <= 1'b0;
      buf_count <= 2'h0;
    end else begin
      buf_mem <= next_buf_mem;
      buf_head <= next_buf_head;
      buf_count <= next_buf_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, read data and interrupts

  assign events[aurx_pkg::EV_CHAR] = push && (buf_count != 2'h2 || pop);
  assign events[aurx_pkg::EV_OVERRUN] = push && buf_count == 2'h2 && !pop;
  assign events[aurx_pkg::EV_FRAMING] = events[aurx_pkg::EV_CHAR] && stop_bad;

  always_comb begin
    next_rx_status_ctrl = rx_status_ctrl;
    next_tx_status_ctrl = tx_status_ctrl;
    next_baud_divisor = baud_divisor;
    next_int_control = int_control;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_reg_rdata = 8'h00;
    if (reg_write) begin
      case (reg_addr)
        aurx_pkg::ADDR_RX_STATUS_CTRL: begin
          next_rx_status_ctrl[7:3] = reg_wdata[7:3];
        end
        aurx_pkg::ADDR_BAUD_DIVISOR: begin
          next_baud_divisor = reg_wdata;
        end
        aurx_pkg::ADDR_TX_STATUS_CTRL: begin
          next_tx_status_ctrl = (reg_wdata & aurx_pkg::TS_WRITE_MASK) |
                                (tx_status_ctrl & ~aurx_pkg::TS_WRITE_MASK);
        end
        aurx_pkg::ADDR_INT_CONTROL: begin
          next_int_control = reg_wdata[2:0];
        end
        aurx_pkg::ADDR_IRQ_MASK: begin
          next_irq_mask = reg_wdata[aurx_pkg::EV_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        aurx_pkg::ADDR_RX_DATA: begin
          next_reg_rdata = buf_count != 2'h0 ? buf_mem[buf_head][7:0] : 8'h00;
        end
        aurx_pkg::ADDR_RX_STATUS_CTRL: begin
          next_reg_rdata = {rx_status_ctrl[7:3], framing_error_flag,
                            overrun_error_flag, rx_ninth_bit};
        end
        aurx_pkg::ADDR_BAUD_DIVISOR: begin
          next_reg_rdata = baud_divisor;
        end
        aurx_pkg::ADDR_TX_STATUS_CTRL: begin
          next_reg_rdata = tx_status_ctrl;
        end
        aurx_pkg::ADDR_INT_CONTROL: begin
          next_reg_rdata = {rx_data_available_flag, 4'h0, int_control};
        end
        aurx_pkg::ADDR_IRQ_STATUS: begin
          next_reg_rdata = {5'h00, irq_status};
          next_irq_status = '0;
        end
        aurx_pkg::ADDR_IRQ_MASK: begin
          next_reg_rdata = {5'h00, irq_mask};
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
    // Set wins over the read clear
    next_irq_status = next_irq_status | events;
    if (events[aurx_pkg::EV_OVERRUN]) begin
      next_rx_status_ctrl[aurx_pkg::RS_OVERRUN] = 1'b1;
    end
    if (!next_rx_status_ctrl[aurx_pkg::RS_CONT_RX] ||
        !next_rx_status_ctrl[aurx_pkg::RS_PORT_ENABLE]) begin
      next_rx_status_ctrl[aurx_pkg::RS_OVERRUN] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_status_ctrl <= aurx_pkg::RX_STATUS_CTRL_RESET;
      tx_status_ctrl <= aurx_pkg::TX_STATUS_CTRL_RESET;
      baud_divisor <= aurx_pkg::BAUD_DIVISOR_RESET;
      int_control <= 3'h0;
      irq_status <= '0;
      irq_mask <= '0;
      reg_rdata <= aurx_pkg::RX_DATA_RESET;
    end else begin
      rx_status_ctrl <= next_rx_status_ctrl;
      tx_status_ctrl <= next_tx_status_ctrl;
      baud_divisor <= next_baud_divisor;
      int_control <= next_int_control;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Receive request needs all three enables
  assign rx_int_request = rx_data_available_flag &&
                          int_control[aurx_pkg::IC_RX_INT_ENABLE] &&
                          int_control[aurx_pkg::IC_PERIPH_INT_ENABLE] &&
                          int_control[aurx_pkg::IC_GLOBAL_INT_ENABLE];
  assign irq = |(irq_status & irq_mask);

endmodule

// file: core/aurx_tick_gen.sv
`timescale 1ns/1ps
// Sixteen-times oversample tick, restarted whenever the receiver idles
module aurx_tick_gen #(
  parameter int CNT_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  aurx_tick_if.gen tk
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] reload;

  // Period in clocks is divisor plus one, times four in low-baud mode
  always_comb begin
    reload = CNT_W'(tk.baud_divisor);
    if (!tk.high_baud_select) begin
      reload = CNT_W'((32'(tk.baud_divisor) + 32'd1) * aurx_pkg::LOW_BAUD_MULT - 32'd1);
    end
    next_count = count - CNT_W'(1);
    if (!tk.run || count == '0) begin
      next_count = reload;
    end
    tk.tick = tk.run && count == '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// file: core/aurx_tick_if.sv
`timescale 1ns/1ps
// Oversample tick request and answer between receiver and tick generator
interface aurx_tick_if;
  logic run;
  logic high_baud_select;
  logic [7:0] baud_divisor;
  logic tick;
  modport rx (output run, output high_baud_select, output baud_divisor, input tick);
  modport gen (input run, input high_baud_select, input baud_divisor, output tick);
endinterface

// file: sim/aurx_receiver_chk.sv
`timescale 1ns/1ps
// Port-level checks of the serial receiver
module aurx_receiver_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic rx_line,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_int_request,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Read port behaviour
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

  property p_unmapped;
    reg_read && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_tx_shift_empty;
    reg_read && reg_addr == aurx_pkg::ADDR_TX_STATUS_CTRL
      |=> reg_rdata[aurx_pkg::TS_TX_SHIFT_EMPTY] && !reg_rdata[3];
  endproperty
  a_tx_shift_empty: assert property (p_tx_shift_empty) else $error("transmit status fixed bits wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and flag relations
  property p_int_req;
    reg_read && reg_addr == aurx_pkg::ADDR_INT_CONTROL
      |=> (&{reg_rdata[7], reg_rdata[2:0]}) == $past(rx_int_request);
  endproperty
  a_int_req: assert property (p_int_req) else $error("interrupt request gating wrong");

  property p_avail_fall;
    $fell(rx_int_request) |-> $past(reg_write)
      || ($past(reg_read) && $past(reg_addr) == aurx_pkg::ADDR_RX_DATA);
  endproperty
  a_avail_fall: assert property (p_avail_fall) else $error("request fell unprompted");

  property p_mask_zero;
    reg_read && reg_addr == aurx_pkg::ADDR_IRQ_MASK
      |=> reg_rdata[2:0] != 3'h0 || !$past(irq);
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("irq high with empty mask");

  ////////////////////////////////////////////////////////////////////////////
  // Status register effects of control writes
  property p_port_off;
    reg_write && reg_addr == aurx_pkg::ADDR_RX_STATUS_CTRL
      && !reg_wdata[aurx_pkg::RS_PORT_ENABLE]
      ##2 reg_read && reg_addr == aurx_pkg::ADDR_RX_STATUS_CTRL |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_port_off: assert property (p_port_off) else $error("flags kept after port off");

  property p_cont_off;
    reg_write && reg_addr == aurx_pkg::ADDR_RX_STATUS_CTRL
      && !reg_wdata[aurx_pkg::RS_CONT_RX]
      ##2 reg_read && reg_addr == aurx_pkg::ADDR_RX_STATUS_CTRL
      |=> !reg_rdata[aurx_pkg::RS_OVERRUN];
  endproperty
  a_cont_off: assert property (p_cont_off) else $error("overrun kept after rx off");

  property p_ninth_addr;
    reg_read && reg_addr == aurx_pkg::ADDR_RX_STATUS_CTRL && rx_int_request
      |=> !reg_rdata[aurx_pkg::RS_ADDR_DETECT] || reg_rdata[aurx_pkg::RS_NINTH];
  endproperty
  a_ninth_addr: assert property (p_ninth_addr) else $error("ninth bit low in address mode");
endmodule

// file: sim/aurx_serial_tx.sv
`timescale 1ns/1ps
// Far-end transmitter driving the serial line, idle high
module aurx_serial_tx #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clock,
  output logic rx_line
);
  // Clocks per bit, changed by the bench for the low-baud test
  int bit_clks = BIT_CLKS;

  initial rx_line = 1'b1;

  // Hold the line at one level for a number of clocks
  task automatic hold(input logic level, input int clks);
    rx_line <= level;
    repeat (clks) @(posedge clock);
  endtask

  // One character: start, data LSB first, stop, then idle
  task automatic send(input logic [8:0] data, input int nbits, input logic stop);
    hold(1'b0, bit_clks);
    for (int i = 0; i < nbits; i++) begin
      hold(data[i], bit_clks);
    end
    hold(stop, bit_clks);
    hold(1'b1, bit_clks);
  endtask

  // Short low pulse that is gone before mid start bit
  task automatic glitch();
    hold(1'b0, bit_clks / 4);
    hold(1'b1, 2 * bit_clks);
  endtask
endmodule

// file: sim/test_async_uart_receiver.sv
`timescale 1ns/1ps
// Self-checking bench for the serial receiver
module test_async_uart_receiver;
  localparam logic [2:0] a_data = aurx_pkg::ADDR_RX_DATA;
  localparam logic [2:0] a_stat = aurx_pkg::ADDR_RX_STATUS_CTRL;
  localparam logic [2:0] a_baud = aurx_pkg::ADDR_BAUD_DIVISOR;
  localparam logic [2:0] a_txs = aurx_pkg::ADDR_TX_STATUS_CTRL;
  localparam logic [2:0] a_ic = aurx_pkg::ADDR_INT_CONTROL;
  localparam logic [2:0] a_irqs = aurx_pkg::ADDR_IRQ_STATUS;
  localparam logic [2:0] a_mask = aurx_pkg::ADDR_IRQ_MASK;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic rx_line;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic rx_int_request;
  logic irq;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and instances
  always #20 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[FAIL] %0t run timed out", $time);
      report_and_stop();
    end
  end

  aurx_receiver dut_u (.clock(clock), .rst(rst), .rx_line(rx_line), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_int_request(rx_int_request), .irq(irq));
  aurx_serial_tx #(.BIT_CLKS(16)) ser_u (.clock(clock), .rx_line(rx_line));

  ////////////////////////////////////////////////////////////////////////////
  // Register port tasks and comparison
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
    chk(d, exp);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Reset values, read-only bits, unmapped index
    rdchk(a_data, 8'h00);
    rdchk(a_stat, 8'h00);
    rdchk(a_txs, 8'h02);
    rdchk(a_baud, 8'h00);
    rdchk(a_ic, 8'h00);
    rdchk(a_irqs, 8'h00);
    rdchk(a_mask, 8'h00);
    wr(a_txs, 8'hFF);
    rdchk(a_txs, 8'hF7);
    wr(3'h7, 8'hFF);
    rdchk(3'h7, 8'h00);
    wr(a_baud, 8'h5A);
    rdchk(a_baud, 8'h5A);
    wr(a_baud, 8'h00);
    wr(a_txs, 8'h04);
    wr(a_ic, 8'h07);
    wr(a_mask, 8'h07);
    $display("test registers done");
    // Two 8-bit characters, second with a bad stop bit
    wr(a_stat, 8'h90);
    ser_u.send(9'h0A5, 8, 1'b1);
    ser_u.send(9'h03C, 8, 1'b0);
    rdchk(a_ic, 8'h87);
    chk({7'h00, rx_int_request}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rdchk(a_stat, 8'h90);
    rdchk(a_data, 8'hA5);
    rdchk(a_stat, 8'h94);
    rdchk(a_data, 8'h3C);
    rdchk(a_ic, 8'h07);
    rdchk(a_irqs, 8'h05);
    rdchk(a_irqs, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test eight bit done");
    // False start, then a character while receive is off
    ser_u.glitch();
    wr(a_stat, 8'h80);
    ser_u.send(9'h055, 8, 1'b1);
    rdchk(a_ic, 8'h07);
    $display("test no start done");
    // Nine-bit characters until the buffer overruns
    wr(a_stat, 8'hD0);
    ser_u.send(9'h155, 9, 1'b1);
    ser_u.send(9'h0AA, 9, 1'b1);
    ser_u.send(9'h10F, 9, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(a_ic, 8'h07 ^ (8'h01 << i));
      chk({7'h00, rx_int_request}, 8'h00);
    end
    wr(a_ic, 8'h07);
    rdchk(a_stat, 8'hD3);
    rdchk(a_data, 8'h55);
    rdchk(a_stat, 8'hD2);
    rdchk(a_data, 8'hAA);
    ser_u.send(9'h1EE, 9, 1'b1);
    rdchk(a_ic, 8'h07);
    wr(a_stat, 8'hC0);
    rdchk(a_stat, 8'hC0);
    rdchk(a_irqs, 8'h03);
    $display("test overrun done");
    // Address detection on, then off
    wr(a_stat, 8'hC8);
    wr(a_stat, 8'hD8);
    ser_u.send(9'h011, 9, 1'b1);
    ser_u.send(9'h122, 9, 1'b1);
    rdchk(a_stat, 8'hD9);
    rdchk(a_data, 8'h22);
    wr(a_stat, 8'hD0);
    ser_u.send(9'h033, 9, 1'b1);
    rdchk(a_stat, 8'hD0);
    rdchk(a_data, 8'h33);
    $display("test address done");
    // Sync select blocks reception; low-baud ticks every four clocks
    wr(a_txs, 8'h14);
    ser_u.send(9'h066, 9, 1'b1);
    rdchk(a_ic, 8'h07);
    wr(a_txs, 8'h00);
    ser_u.bit_clks = 64;
    ser_u.send(9'h1C3, 9, 1'b1);
    rdchk(a_stat, 8'hD1);
    rdchk(a_data, 8'hC3);
    ser_u.bit_clks = 16;
    wr(a_txs, 8'h04);
    $display("test baud mode done");
    // Masked interrupt, then port switched off with a bad character held
    wr(a_stat, 8'h90);
    ser_u.send(9'h077, 8, 1'b0);
    wr(a_mask, 8'h00);
    rdchk(a_mask, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rdchk(a_stat, 8'h94);
    wr(a_stat, 8'h00);
    rdchk(a_stat, 8'h00);
    rdchk(a_ic, 8'h07);
    rdchk(a_irqs, 8'h05);
    $display("test port off done");
    report_and_stop();
  end
endmodule

// Port checker beside the receiver
bind aurx_receiver aurx_receiver_chk chk_u (.clock(clock), .rst(rst), .rx_line(rx_line),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .rx_int_request(rx_int_request), .irq(irq));
